// *** rtl/nasl_net_lock.sv ***
/*
 * Network address select and command owner lock, top level.
 * Assumes the selector, configuration writes, address grants and
 * parsed packet headers arrive synchronous to clock; arst_n is the
 * power-on reset and is the only thing that frees the owner.
 */
// Notes on behaviour
// RULE_01 - Selector picks one of sixteen address entries
// RULE_02 - Position zero always gives fixed recovery address
// RULE_03 - Positions one to fourteen are writable entries
// RULE_04 - Position fifteen requests a dynamic address
// RULE_05 - Table positions use a sixteen-bit mask
// RULE_06 - Recovery address uses an eight-bit mask
// RULE_07 - UDP commands arrive on port 7775
// RULE_08 - TCP commands arrive on port 7776
// RULE_09 - Same command set on either transport
// RULE_10 - First sender latched; replies go there
// RULE_11 - Other source addresses are discarded once owned
// RULE_12 - Owner lock cleared only by power loss
// RULE_13 - Host picks any unused source port
// RULE_14 - Dynamic mode takes address and mask from server
// RULE_15 - Selector sampled once after power-up, then held
`timescale 1ns/1ps
`include "nasl_defs.svh"

module nasl_net_lock import nasl_pkg::*; #(
    parameter int ENTRIES = 14
) (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    input wire logic clk_en,
    // Address selector
    input wire logic [3:0] selector,
    // Table configuration
    input wire nasl_cfg_write_type cfg_write,
    // Dynamic address assignment
    output logic dyn_request,
    input wire logic dyn_grant_valid,
    input wire nasl_net_type dyn_grant,
    // Active address
    output logic addr_valid,
    output nasl_net_type net_addr,
    // Received packet headers
    input wire logic rx_valid,
    input wire nasl_packet_type rx_pkt,
    // Command decision
    output logic cmd_accept,
    output logic cmd_discard,
    output nasl_packet_type cmd_packet,
    // Owner and reply endpoint
    output logic owned,
    output logic [31:0] reply_ip,
    output logic [15:0] reply_port
);

    nasl_lock_state_type st;
    nasl_lock_state_type next_st;
    nasl_net_type tbl_net;
    logic tbl_dyn;
    logic is_cmd;
    logic accept;
    logic discard;

    // ==========================================================
    // Address table
    nasl_addr_table #(
        .ENTRIES(ENTRIES)
    ) u_table (
        .clock(clock),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .cfg_write(cfg_write),
        .lookup_sel(selector),
        .lookup_net(tbl_net),
        .lookup_dyn(tbl_dyn)
    );

    // ==========================================================
    // Command filter
    nasl_cmd_filter u_filter (
        .pkt_valid(rx_valid),
        .pkt(rx_pkt),
        .owned(st.owned),
        .owner_ip(st.reply_ip),
        .is_cmd(is_cmd),
        .accept(accept),
        .discard(discard)
    );

    // ==========================================================
    // Next state
    always_comb begin
        next_st = st;
        next_st.cmd_accept = 1'b0;
        next_st.cmd_discard = 1'b0;
        unique case (st.phase)
            NASL_PH_SAMPLE: begin
                // One look at the switch; later turns need a power cycle
                if (tbl_dyn) begin // [RULE_04] [RULE_15]
                    next_st.phase = NASL_PH_DYN_WAIT;
                    next_st.dyn_request = 1'b1;
                end else begin // [RULE_01] [RULE_15]
                    next_st.phase = NASL_PH_READY;
                    next_st.net = tbl_net;
                    next_st.addr_valid = 1'b1;
                end
            end
            NASL_PH_DYN_WAIT: begin
                if (dyn_grant_valid) begin // [RULE_14]
                    next_st.phase = NASL_PH_READY;
                    next_st.net = dyn_grant;
                    next_st.addr_valid = 1'b1;
                    next_st.dyn_request = 1'b0;
                end
            end
            NASL_PH_READY: begin
                // No traffic is served before the address is up
                if (accept) begin
                    next_st.cmd_accept = 1'b1;
                    next_st.cmd_packet = rx_pkt;
                    if (!st.owned) begin // [RULE_10]
                        next_st.owned = 1'b1;
                        next_st.reply_ip = rx_pkt.src_ip;
                        next_st.reply_port = rx_pkt.src_port; // [RULE_13]
                    end
                end else if (discard) begin // [RULE_11]
                    next_st.cmd_discard = 1'b1;
                end
            end
            default: begin
                next_st.phase = NASL_PH_SAMPLE;
            end
        endcase
    end

    // ==========================================================
    // State register
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin // [RULE_12]
            st.phase <= NASL_PH_SAMPLE;
            st.dyn_request <= 1'b0;
            st.addr_valid <= 1'b0;
            st.net.ip <= `NASL_ZERO_IP;
            st.net.mask <= `NASL_ZERO_IP;
            st.cmd_accept <= 1'b0;
            st.cmd_discard <= 1'b0;
            st.cmd_packet.proto <= NASL_UDP;
            st.cmd_packet.src_ip <= `NASL_ZERO_IP;
            st.cmd_packet.src_port <= `NASL_ZERO_PORT;
            st.cmd_packet.dst_port <= `NASL_ZERO_PORT;
            st.owned <= 1'b0;
            st.reply_ip <= `NASL_ZERO_IP;
            st.reply_port <= `NASL_ZERO_PORT;
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    // ==========================================================
    // Outputs
    assign dyn_request = st.dyn_request;
    assign addr_valid = st.addr_valid;
    assign net_addr = st.net;
    assign cmd_accept = st.cmd_accept;
    assign cmd_discard = st.cmd_discard;
    assign cmd_packet = st.cmd_packet;
    assign owned = st.owned;
    assign reply_ip = st.reply_ip;
    assign reply_port = st.reply_port;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);

    logic in_sample;
    logic in_ready;
    logic cmd_seen;
    // Release edge still runs the reset branch, so it is no sampling edge
    assign in_sample = arst_n && clk_en && (st.phase == NASL_PH_SAMPLE);
    assign in_ready = arst_n && clk_en && (st.phase == NASL_PH_READY);
    assign cmd_seen = in_ready && is_cmd;

    a_recovery_addr: assert property ( // [RULE_02] [RULE_06]
        (in_sample && selector == `NASL_SEL_RECOVERY)
        |=> addr_valid && net_addr.ip == `NASL_RECOVERY_IP
            && net_addr.mask == `NASL_MASK_CLASS_A)
        else $error("recovery address or mask wrong");

    a_table_mask: assert property ( // [RULE_01] [RULE_05]
        (in_sample && selector >= `NASL_SEL_FIRST && selector <= `NASL_SEL_LAST)
        |=> addr_valid && net_addr.mask == `NASL_MASK_CLASS_B
            && net_addr.ip == $past(tbl_net.ip))
        else $error("table address or mask wrong");

    a_dyn_request: assert property ( // [RULE_04]
        (in_sample && selector == `NASL_SEL_DYN)
        |=> dyn_request && !addr_valid)
        else $error("dynamic request not raised");

    a_dyn_grant: assert property ( // [RULE_14]
        (clk_en && st.phase == NASL_PH_DYN_WAIT && dyn_grant_valid)
        |=> addr_valid && !dyn_request && net_addr == $past(dyn_grant))
        else $error("granted address not applied");

    a_addr_held: assert property ( // [RULE_15]
        addr_valid |=> addr_valid && $stable(net_addr) && !dyn_request)
        else $error("address changed after power-up");

    a_owner_latch: assert property ( // [RULE_10]
        (cmd_seen && !owned)
        |=> owned && cmd_accept && reply_ip == $past(rx_pkt.src_ip)
            && reply_port == $past(rx_pkt.src_port))
        else $error("first sender not latched");

    a_foreign_drop: assert property ( // [RULE_11]
        (cmd_seen && owned && rx_pkt.src_ip != reply_ip)
        |=> cmd_discard && !cmd_accept)
        else $error("foreign sender not discarded");

    a_owner_accept: assert property ( // [RULE_09]
        (cmd_seen && owned && rx_pkt.src_ip == reply_ip)
        |=> cmd_accept && !cmd_discard && cmd_packet == $past(rx_pkt))
        else $error("owner command not accepted");

    a_owner_kept: assert property ( // [RULE_12]
        owned |=> owned && $stable(reply_ip) && $stable(reply_port))
        else $error("owner lock released while powered");

    a_cmd_port: assert property ( // [RULE_07] [RULE_08]
        (cmd_accept && $past(clk_en))
        |-> (cmd_packet.proto == NASL_UDP && cmd_packet.dst_port == `NASL_UDP_CMD_PORT)
            || (cmd_packet.proto == NASL_TCP && cmd_packet.dst_port == `NASL_TCP_CMD_PORT))
        else $error("command accepted on wrong port");

    a_no_early_cmd: assert property (
        !addr_valid |-> !cmd_accept && !cmd_discard && !owned)
        else $error("traffic served before address up");

    // ==========================================================
    // Checks: dynamic phase and held address
    a_dyn_only_f: assert property ( // [RULE_04]
        (in_sample && selector != `NASL_SEL_DYN) |=> !dyn_request)
        else $error("dynamic request on table position");

    a_dyn_wait_hold: assert property ( // [RULE_04]
        (clk_en && st.phase == NASL_PH_DYN_WAIT && !dyn_grant_valid)
        |=> dyn_request && !addr_valid)
        else $error("dynamic wait left without grant");

    // Nothing may show on net_addr until the server answers
    a_dyn_zero: assert property ( // [RULE_14]
        dyn_request |-> net_addr.ip == `NASL_ZERO_IP && net_addr.mask == `NASL_ZERO_IP)
        else $error("address shown before grant");

    a_sample_once: assert property ( // [RULE_15]
        st.phase != NASL_PH_SAMPLE |=> st.phase != NASL_PH_SAMPLE)
        else $error("selector sampled twice");

    a_grant_refused: assert property ( // [RULE_15]
        (in_ready && dyn_grant_valid) |=> addr_valid && $stable(net_addr))
        else $error("grant applied outside wait phase");

    // Enable low must hold every field, pulses included
    a_state_frozen: assert property (
        !clk_en |=> $stable(st))
        else $error("state moved with enable low");

    // ==========================================================
    // Checks: command pulses
    // A frozen enable stretches a pulse; only an enabled edge ends it
    a_accept_cause: assert property ( // [RULE_09]
        (clk_en && !(in_ready && accept)) |=> !cmd_accept)
        else $error("accept pulse without command");

    a_discard_cause: assert property ( // [RULE_11]
        (clk_en && !(in_ready && discard)) |=> !cmd_discard)
        else $error("discard pulse without foreign command");

    a_other_port: assert property ( // [RULE_07] [RULE_08]
        (in_ready && rx_valid && !is_cmd)
        |=> !cmd_accept && !cmd_discard)
        else $error("non-command packet answered");

    a_idle_quiet: assert property ( // [RULE_07]
        (clk_en && !rx_valid) |=> !cmd_accept && !cmd_discard)
        else $error("pulse without a packet");

    a_pulse_excl: assert property ( // [RULE_11]
        !(cmd_accept && cmd_discard))
        else $error("accept and discard together");

    a_owner_first: assert property ( // [RULE_10]
        cmd_accept |-> owned)
        else $error("command accepted without owner");

    a_owner_cause: assert property ( // [RULE_10]
        (clk_en && !owned && !(in_ready && accept)) |=> !owned)
        else $error("owner set without a command");

    a_copy_held: assert property ( // [RULE_09]
        (clk_en && !(in_ready && accept)) |=> $stable(cmd_packet))
        else $error("command copy changed without accept");

    c_recovery: cover property (in_sample && selector == `NASL_SEL_RECOVERY);
    c_dyn_grant: cover property (dyn_request ##[1:20] addr_valid);
    c_owner_cmd: cover property (cmd_accept && owned ##[1:20] cmd_accept);
    c_foreign: cover property (owned ##[1:20] cmd_discard);
    c_tcp_owner: cover property (cmd_accept && cmd_packet.proto == NASL_TCP);

endmodule

// *** rtl/nasl_defs.svh ***
/*
 * Constants of the network address select and owner lock block:
 * selector codes, fixed addresses, masks and command ports.
 * Assumes inclusion by bare name from rtl/ modules.
 */
`ifndef NASL_DEFS_SVH
`define NASL_DEFS_SVH

// ==========================================================
// Selector positions
`define NASL_SEL_RECOVERY 4'h0
`define NASL_SEL_FIRST 4'h1
`define NASL_SEL_LAST 4'hE
`define NASL_SEL_DYN 4'hF

// ==========================================================
// Addresses and masks
`define NASL_RECOVERY_IP 32'h0A0A0A0A
`define NASL_MASK_CLASS_A 32'hFF000000
`define NASL_MASK_CLASS_B 32'hFFFF0000
`define NASL_NET_UPPER 32'hC0A80100
`define NASL_NET_LOWER 32'hC0A80000
`define NASL_UPPER_LAST 4'h3
`define NASL_HOST_STEP 8'h0A
`define NASL_ZERO_IP 32'h00000000

// ==========================================================
// Command ports
`define NASL_UDP_CMD_PORT 16'h1E5F
`define NASL_TCP_CMD_PORT 16'h1E60
`define NASL_ZERO_PORT 16'h0000

`endif

// *** rtl/nasl_pkg.sv ***
/*
 * Types shared by the address select and owner lock modules.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package nasl_pkg;

    typedef enum logic {
        NASL_UDP = 1'b0,
        NASL_TCP = 1'b1
    } nasl_proto_type;

    typedef struct packed {
        nasl_proto_type proto;
        logic [31:0] src_ip;
        logic [15:0] src_port;
        logic [15:0] dst_port;
    } nasl_packet_type;

    typedef struct packed {
        logic [31:0] ip;
        logic [31:0] mask;
    } nasl_net_type;

    typedef struct packed {
        logic valid;
        logic [3:0] index;
        logic [31:0] ip;
    } nasl_cfg_write_type;

    typedef enum logic [1:0] {
        NASL_PH_SAMPLE = 2'b00,
        NASL_PH_DYN_WAIT = 2'b01,
        NASL_PH_READY = 2'b10
    } nasl_phase_type;

    typedef struct packed {
        nasl_phase_type phase;
        logic dyn_request;
        logic addr_valid;
        nasl_net_type net;
        logic cmd_accept;
        logic cmd_discard;
        nasl_packet_type cmd_packet;
        logic owned;
        logic [31:0] reply_ip;
        logic [15:0] reply_port;
    } nasl_lock_state_type;

endpackage

// *** rtl/nasl_addr_table.sv ***
/*
 * Address table: fourteen writable entries behind selector
 * positions one to fourteen, fixed recovery entry, dynamic code.
 * Assumes the configuration write port is driven synchronously.
 */
`timescale 1ns/1ps
`include "nasl_defs.svh"

module nasl_addr_table import nasl_pkg::*; #(
    parameter int ENTRIES = 14
) (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    input wire logic clk_en,
    // Configuration write
    input wire nasl_cfg_write_type cfg_write,
    // Lookup
    input wire logic [3:0] lookup_sel,
    output nasl_net_type lookup_net,
    output logic lookup_dyn
);

    typedef struct packed {
        logic [ENTRIES-1:0][31:0] entry;
    } nasl_table_state_type;

    nasl_table_state_type st;
    nasl_table_state_type next_st;

    function automatic logic is_table_sel(input logic [3:0] sel);
        return (sel >= `NASL_SEL_FIRST) && (sel <= `NASL_SEL_LAST);
    endfunction

    function automatic logic [31:0] factory_ip(input int pos);
        logic [7:0] host;
        host = 8'(pos) * `NASL_HOST_STEP;
        return ((pos <= int'(`NASL_UPPER_LAST)) ? `NASL_NET_UPPER : `NASL_NET_LOWER)
            | {24'h000000, host};
    endfunction

    // ==========================================================
    // Storage
    always_comb begin
        next_st = st;
        // Position zero has no slot, so it can never be overwritten
        if (cfg_write.valid && is_table_sel(cfg_write.index)) begin // [RULE_02] [RULE_03]
            next_st.entry[4'(cfg_write.index - `NASL_SEL_FIRST)] = cfg_write.ip;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < ENTRIES; i++) begin
                st.entry[i] <= factory_ip(i + 1);
            end
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    // ==========================================================
    // Lookup
    always_comb begin
        lookup_dyn = 1'b0;
        lookup_net.ip = `NASL_ZERO_IP;
        lookup_net.mask = `NASL_ZERO_IP;
        if (lookup_sel == `NASL_SEL_RECOVERY) begin // [RULE_02] [RULE_06]
            lookup_net.ip = `NASL_RECOVERY_IP;
            lookup_net.mask = `NASL_MASK_CLASS_A;
        end else if (lookup_sel == `NASL_SEL_DYN) begin // [RULE_04]
            lookup_dyn = 1'b1;
        end else if (is_table_sel(lookup_sel)) begin // [RULE_01] [RULE_05]
            lookup_net.ip = st.entry[4'(lookup_sel - `NASL_SEL_FIRST)];
            lookup_net.mask = `NASL_MASK_CLASS_B;
        end
    end

    // ==========================================================
    // Checks
    a_table_write: assert property (@(posedge clock) disable iff (!arst_n) // [RULE_03]
        (clk_en && cfg_write.valid && is_table_sel(cfg_write.index))
        |=> st.entry[4'($past(cfg_write.index) - `NASL_SEL_FIRST)] == $past(cfg_write.ip))
        else $error("table entry not written");

endmodule

// *** rtl/nasl_cmd_filter.sv ***
/*
 * Command port classifier: marks packets for the command ports
 * and splits them into accepted and discarded by owner address.
 * Assumes the packet fields are stable while valid is high.
 */
`timescale 1ns/1ps
`include "nasl_defs.svh"

module nasl_cmd_filter import nasl_pkg::*; (
    // Packet
    input wire logic pkt_valid,
    input wire nasl_packet_type pkt,
    // Owner
    input wire logic owned,
    input wire logic [31:0] owner_ip,
    // Decision
    output logic is_cmd,
    output logic accept,
    output logic discard
);

    // ==========================================================
    // Decision
    always_comb begin
        // Same command set on either transport
        is_cmd = pkt_valid && (
            ((pkt.proto == NASL_UDP) && (pkt.dst_port == `NASL_UDP_CMD_PORT)) || // [RULE_07]
            ((pkt.proto == NASL_TCP) && (pkt.dst_port == `NASL_TCP_CMD_PORT)));  // [RULE_08] [RULE_09]
        // Only the address is compared; owner may change its port
        discard = is_cmd && owned && (pkt.src_ip != owner_ip); // [RULE_11]
        accept = is_cmd && !discard;
    end

endmodule

// *** testbench/nasl_host_model.sv ***
/*
 * Host application model: sends parsed command headers to the block.
 * Assumes the bench calls send and idle from one process only.
 */
`timescale 1ns/1ps

module nasl_host_model import nasl_pkg::*; (
    // Clock
    input wire logic clock,
    // Headers towards the device
    output logic rx_valid,
    output nasl_packet_type rx_pkt
);
    // ==========================================================
    // Drivers
    initial begin
        rx_valid = 1'b0;
        rx_pkt = '0;
    end

    // One header per edge, so calls may follow back to back
    task automatic send(input nasl_packet_type p);
        @(posedge clock);
        rx_valid <= 1'b1;
        rx_pkt <= p; // Any source port, chosen destination
    endtask

    // Released fields flip, so no stale header is left on the lines
    task automatic idle();
        @(posedge clock);
        rx_valid <= 1'b0;
        rx_pkt <= ~rx_pkt;
    endtask
endmodule

// *** testbench/nasl_net_lock_bench.sv ***
/*
 * Self-checking bench of the address select and owner lock block.
 * Assumes nasl_pkg compiled first and the host model beside it.
 */
`timescale 1ns/1ps

module nasl_net_lock_bench import nasl_pkg::*;;
    // ==========================================================
    // Signals
    logic clock, arst_n, clk_en, dyn_grant_valid, dyn_request, addr_valid;
    logic cmd_accept, cmd_discard, owned, rx_valid;
    logic [3:0] selector;
    logic [31:0] reply_ip;
    logic [15:0] reply_port;
    nasl_cfg_write_type cfg_write;
    nasl_net_type dyn_grant, net_addr;
    nasl_packet_type rx_pkt, cmd_packet;
    int err_total = 0;
    int n_checks = 0;
    int cycles = 0;
    localparam logic [31:0] IP_A = 32'hC0A80116;
    localparam logic [31:0] IP_B = 32'hC0A80117;

    nasl_net_lock dut (.clock(clock), .arst_n(arst_n), .clk_en(clk_en),
        .selector(selector), .cfg_write(cfg_write), .dyn_request(dyn_request),
        .dyn_grant_valid(dyn_grant_valid), .dyn_grant(dyn_grant),
        .addr_valid(addr_valid), .net_addr(net_addr), .rx_valid(rx_valid),
        .rx_pkt(rx_pkt), .cmd_accept(cmd_accept), .cmd_discard(cmd_discard),
        .cmd_packet(cmd_packet), .owned(owned), .reply_ip(reply_ip),
        .reply_port(reply_port));
    nasl_host_model h (.clock(clock), .rx_valid(rx_valid), .rx_pkt(rx_pkt));

    // ==========================================================
    // Clock and timeout
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            stop_test();
        end
    end

    // ==========================================================
    // Compare and helper tasks
    task automatic cmp_bit(input string name, input logic exp, input logic got);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic cmp_word(input string name, input logic [64:0] exp,
                            input logic [64:0] got);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_pulse(input logic acc, input logic dis);
        @(negedge clock);
        cmp_bit("cmd_accept", acc, cmd_accept);
        cmp_bit("cmd_discard", dis, cmd_discard);
    endtask

    // Power cycle; bounded wait for the address phase to settle
    task automatic do_reset(input logic [3:0] sel);
        int n;
        n = 0;
        @(posedge clock);
        arst_n <= 1'b0;
        selector <= sel;
        repeat (3) @(posedge clock);
        @(negedge clock);
        cmp_bit("owned", 1'b0, owned);
        cmp_bit("addr_valid", 1'b0, addr_valid);
        @(posedge clock);
        arst_n <= 1'b1;
        repeat (2) @(negedge clock);
        while (addr_valid !== 1'b1 && dyn_request !== 1'b1 && n < 6) begin
            @(negedge clock);
            n++;
        end
        cmp_bit("address_phase", 1'b1, addr_valid | dyn_request);
    endtask

    // ==========================================================
    // Scenarios
    // Every table position, then selector and table changed after sampling
    task automatic test_table();
        logic [31:0] ip;
        logic [31:0] mask;
        for (int p = 0; p < 15; p++) begin
            do_reset(4'(p));
            ip = (p < 4) ? 32'hC0A80100 : 32'hC0A80000;
            ip = ip + 32'(p * 10);
            mask = 32'hFFFF0000;
            if (p == 0) begin
                ip = 32'h0A0A0A0A;
                mask = 32'hFF000000;
            end
            cmp_word("net_addr", {1'b0, ip, mask}, {1'b0, net_addr});
            @(posedge clock);
            selector <= ~4'(p);
            cfg_write <= '{1'b1, 4'(p), 32'h01020304};
            @(posedge clock);
            cfg_write <= '{1'b0, 4'h0, 32'h00000000};
            repeat (2) @(negedge clock);
            cmp_word("net_held", {1'b0, ip, mask}, {1'b0, net_addr});
            if (p > 0) begin
                cmp_word("entry", 65'h01020304, 65'(dut.u_table.st.entry[p - 1]));
            end
        end
    endtask

    // Dynamic mode: wait for grant, commands ignored until then
    task automatic test_dyn();
        do_reset(4'hF);
        cmp_bit("dyn_request", 1'b1, dyn_request);
        cmp_word("net_zero", 65'h0, {1'b0, net_addr});
        h.send('{NASL_UDP, IP_A, 16'h1388, 16'h1E5F});
        h.idle();
        chk_pulse(1'b0, 1'b0);
        @(posedge clock);
        dyn_grant_valid <= 1'b1;
        dyn_grant <= '{32'h0A000063, 32'hFFFFFF00};
        @(posedge clock);
        dyn_grant_valid <= 1'b0;
        dyn_grant <= ~dyn_grant;
        @(negedge clock);
        cmp_bit("addr_valid", 1'b1, addr_valid);
        cmp_bit("dyn_request", 1'b0, dyn_request);
        cmp_word("net_dyn", {33'h0, 32'h0A000063}, {33'h0, net_addr.ip});
        cmp_word("mask_dyn", 65'hFFFFFF00, {33'h0, net_addr.mask});
        @(posedge clock);
        dyn_grant_valid <= 1'b1;
        @(posedge clock);
        dyn_grant_valid <= 1'b0;
        @(negedge clock);
        cmp_word("ip_kept", 65'h0A000063, {33'h0, net_addr.ip});
    endtask

    // Ownership, foreign senders, transports and wrong ports
    task automatic test_lock();
        nasl_packet_type t;
        t = '{NASL_TCP, IP_A, 16'h2000, 16'h1E60};
        do_reset(4'h1);
        h.send('{NASL_UDP, IP_A, 16'h1388, 16'h1E5F});
        h.send('{NASL_UDP, IP_B, 16'h1389, 16'h1E5F});
        chk_pulse(1'b1, 1'b0);
        cmp_bit("owned", 1'b1, owned);
        cmp_word("reply_ip", {33'h0, IP_A}, {33'h0, reply_ip});
        cmp_word("reply_port", 65'h1388, {49'h0, reply_port});
        h.send(t);
        chk_pulse(1'b0, 1'b1);
        h.send('{NASL_UDP, IP_A, 16'h1389, 16'h1E60});
        chk_pulse(1'b1, 1'b0);
        cmp_word("cmd_packet", 65'(t), 65'(cmd_packet));
        cmp_word("reply_port", 65'h1388, {49'h0, reply_port});
        h.send('{NASL_TCP, IP_A, 16'h1389, 16'h1E5F});
        chk_pulse(1'b0, 1'b0);
        h.send('{NASL_TCP, IP_B, 16'h0001, 16'h1E60});
        chk_pulse(1'b0, 1'b0);
        h.idle();
        chk_pulse(1'b0, 1'b1);
        repeat (50) @(negedge clock);
        cmp_bit("owned", 1'b1, owned);
        cmp_word("reply_ip", {33'h0, IP_A}, {33'h0, reply_ip});
    endtask

    // Power cycle frees the lock; a new sender owns over TCP; enable low freezes
    task automatic test_relock();
        do_reset(4'h0);
        h.send('{NASL_TCP, IP_B, 16'hFFFF, 16'h1E60});
        h.idle();
        clk_en <= 1'b0;
        chk_pulse(1'b1, 1'b0);
        cmp_word("reply_ip", {33'h0, IP_B}, {33'h0, reply_ip});
        cmp_word("reply_port", 65'hFFFF, {49'h0, reply_port});
        chk_pulse(1'b1, 1'b0);
        @(posedge clock);
        clk_en <= 1'b1;
    endtask

    // ==========================================================
    // Verdict
    task automatic stop_test();
        if (err_total == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        arst_n = 1'b0;
        clk_en = 1'b1;
        selector = 4'h0;
        cfg_write = '0;
        dyn_grant_valid = 1'b0;
        dyn_grant = '0;
        test_table();
        test_dyn();
        test_lock();
        test_relock();
        stop_test();
    end
endmodule
